// File: design/jnp_pkg.sv
// How it works
// RL1: Instruction 0x5 puts the 15-bit command register between TDI and TDO.
// RL2: Capture-DR under command entry loads the previous command's result.
// RL3: Shift-DR shifts the command register once per TCK, result out, command in.
// RL4: Update-DR presents the shifted command to the NVM inputs, not yet executed; here nvm_cmd changes only with the execute pulse.
// RL5: Run-Test/Idle after a command update yields exactly one execute pulse.
// RL6: Instruction 0x6 shifts the 8-bit data byte, the command register's low bits.
// RL7: Page-load Update-DR copies the byte and writes the page buffer within 11 TCK.
// RL8: Page-load writes alternate low then high byte, starting low after entry.
// RL9: Page-load increments the counter before each low byte except the first.
// RL10: Instruction 0x7 captures the addressed Flash byte into the data byte.
// RL11: Page-read captures alternate low then high byte, starting low after entry.
// RL12: Page-read increments the counter after every high byte read.
// RL13: A one in the reset data register holds the core in reset at once.
// RL14: After the reset bit clears, reset stays for the clock-option time-out.
// RL15: Programmer resets the device through the reset register before programming.
// RL16: Programming is enabled only when the 16-bit enable register equals the signature.
// RL17: Enable register clears on power-on reset; programmer clears it on leaving.
// RL18: Programmer chip-erase sequence with completion polling.
// RL19: Programmer Flash write: enter, load address bytes, load data bytes.
// RL20: Programmer latch-data and page-commit sequences with polling.
// RL21: Programmer Flash read: enter, load address, read low then high byte.
// RL22: Programmer EEPROM write: enter, address, data, latch, commit page.
// RL23: All test-port shift registers move least significant bit first.
// RL24: Instruction register is 4 bits; 0xC selects reset register, TAP not reset.
// RL25: Under 0x4, Update-DR compares the signature and enters programming mode.
// RL26: Programmer may skip a latch or write sequence if upper bits already set.
// RL27: Command is 7-bit command field over 8-bit data; results in low 8 bits.
// RL28: TAP controller follows the published boundary-scan state machine on TCK.
package jnp_pkg;
	localparam logic [3:0]  INS_PROGRAMMING_ENABLE_INSTRUCTION = 4'h4;
	localparam logic [3:0]  INS_COMMAND     = 4'h5;
	localparam logic [3:0]  INS_PAGE_LOAD   = 4'h6;
	localparam logic [3:0]  INS_PAGE_READ   = 4'h7;
	localparam logic [3:0]  INS_DEV_RESET   = 4'hc;
	localparam logic [3:0]  INS_BYPASS      = 4'hf;
	localparam logic [3:0]  IR_CAPTURE      = 4'h1;
	localparam int          IR_W            = 4;
	localparam int          CMD_W           = 15;
	localparam int          BYTE_W          = 8;
	localparam int          PE_W            = 16;
	localparam logic [15:0] PE_SIGNATURE    = 16'ha370;
	localparam logic [15:0] PE_RESET        = 16'h0000;
	localparam int          CLK_PERIOD_NS   = 25;
	localparam int          SHORT_TIMEOUT_NS = 4100;
	localparam int          SHORT_TIMEOUT_CYC = (SHORT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          LONG_TIMEOUT_MS = 65;
	localparam int          LONG_TIMEOUT_CYC = (LONG_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
	localparam int          TIMEOUT_W       = 22;
	localparam int          STAT_W          = CMD_W + 16;

	typedef enum logic [15:0] {
		TAP_RESET = 16'h0001,
		TAP_IDLE  = 16'h0002,
		TAP_SELDR = 16'h0004,
		TAP_CAPDR = 16'h0008,
		TAP_SHFDR = 16'h0010,
		TAP_EX1DR = 16'h0020,
		TAP_PAUDR = 16'h0040,
		TAP_EX2DR = 16'h0080,
		TAP_UPDDR = 16'h0100,
		TAP_SELIR = 16'h0200,
		TAP_CAPIR = 16'h0400,
		TAP_SHFIR = 16'h0800,
		TAP_EX1IR = 16'h1000,
		TAP_PAUIR = 16'h2000,
		TAP_EX2IR = 16'h4000,
		TAP_UPDIR = 16'h8000
	} jnp_tap_state_type;
endpackage

// File: design/jnp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module jnp_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic din,
	output var  logic q
);
	logic s1;
	logic s2;
	logic s3;

	// The first stage feeds only the second; a change counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			q  <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				q <= s3;
			end
		end
	end
endmodule
`default_nettype wire

// File: design/jnp_tap_fsm.sv
`timescale 1ns/10ps
`default_nettype none
module jnp_tap_fsm
	import jnp_pkg::*;
(
	input  wire logic        tck,
	input  wire logic        rst_n,
	input  wire logic        tms,
	output var  jnp_tap_state_type state
);
	jnp_tap_state_type next_state;

	always_comb begin
		case (state)
			TAP_RESET: next_state = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE:  next_state = tms ? TAP_SELDR : TAP_IDLE;
			TAP_SELDR: next_state = tms ? TAP_SELIR : TAP_CAPDR;
			TAP_CAPDR: next_state = tms ? TAP_EX1DR : TAP_SHFDR;
			TAP_SHFDR: next_state = tms ? TAP_EX1DR : TAP_SHFDR;
			TAP_EX1DR: next_state = tms ? TAP_UPDDR : TAP_PAUDR;
			TAP_PAUDR: next_state = tms ? TAP_EX2DR : TAP_PAUDR;
			TAP_EX2DR: next_state = tms ? TAP_UPDDR : TAP_SHFDR;
			TAP_UPDDR: next_state = tms ? TAP_SELDR : TAP_IDLE;
			TAP_SELIR: next_state = tms ? TAP_RESET : TAP_CAPIR;
			TAP_CAPIR: next_state = tms ? TAP_EX1IR : TAP_SHFIR;
			TAP_SHFIR: next_state = tms ? TAP_EX1IR : TAP_SHFIR;
			TAP_EX1IR: next_state = tms ? TAP_UPDIR : TAP_PAUIR;
			TAP_PAUIR: next_state = tms ? TAP_EX2IR : TAP_PAUIR;
			TAP_EX2IR: next_state = tms ? TAP_UPDIR : TAP_SHFIR;
			TAP_UPDIR: next_state = tms ? TAP_SELDR : TAP_IDLE;
			default:   next_state = TAP_RESET;
		endcase
	end

	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			state <= TAP_RESET;
		end else begin
			state <= next_state; // RL28
		end
	end
endmodule
`default_nettype wire

// File: design/jnp_prog_port.sv
`timescale 1ns/10ps
`default_nettype none
module jnp_prog_port
	import jnp_pkg::*;
#(
	parameter int LONG_TIMEOUT_CYCLES = LONG_TIMEOUT_CYC
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              tck,
	input  wire logic              tms,
	input  wire logic              tdi,
	output var  logic              tdo,
	output var  logic              tdo_oe_n,
	input  wire logic              clk_opt_long,
	input  wire logic [CMD_W-1:0]  nvm_result,
	input  wire logic [15:0]       nvm_read_word,
	output var  logic [CMD_W-1:0]  nvm_cmd,
	output var  logic              nvm_exec,
	output var  logic [BYTE_W-1:0] load_byte,
	output var  logic              load_high,
	output var  logic              load_strobe,
	output var  logic              pc_inc,
	output var  logic              core_reset,
	output var  logic              prog_enabled
);
	// ---------------- TCK domain ----------------
	jnp_tap_state_type state;
	logic [IR_W-1:0]   ir_sr;
	logic [IR_W-1:0]   ir;
	logic [CMD_W-1:0]  cmd_sr;
	logic [CMD_W-1:0]  cmd_applied;
	logic [PE_W-1:0]   pe_sr;
	logic              prog_mode;
	logic              rst_bit;
	logic              bypass;
	logic              exec_pending;
	logic              exec_tgl;
	logic              pl_tgl;
	logic              pl_high;
	logic              pl_first;
	logic              pl_preinc;
	logic [BYTE_W-1:0] pl_byte;
	logic              pr_high;
	logic              pr_tgl;
	logic [STAT_W-1:0] stat_tck;
	logic              stat_ack;
	logic              stat_req_t;
	logic              tdo_bit;

	// ---------------- clk domain ----------------
	logic [STAT_W-1:0]    stat_hold;
	logic                 stat_req;
	logic                 stat_ack_c;
	logic                 exec_c;
	logic                 exec_seen;
	logic                 pl_c;
	logic                 pl_seen;
	logic                 pr_c;
	logic                 pr_seen;
	logic                 load_pending;
	logic                 rst_bit_c;
	logic                 prog_mode_c;
	logic [TIMEOUT_W-1:0] tmo_cnt;
	logic                 tmo_arm;

	logic sel_cmd;
	logic sel_byte;
	logic sel_pe;
	logic sel_rst;

	assign sel_cmd  = (ir == INS_COMMAND); // RL1
	assign sel_byte = (ir == INS_PAGE_LOAD) || (ir == INS_PAGE_READ); // RL6 RL10
	assign sel_pe   = (ir == INS_PROGRAMMING_ENABLE_INSTRUCTION);
	assign sel_rst  = (ir == INS_DEV_RESET); // RL24

	jnp_tap_fsm u_tap (
		.tck   (tck),
		.rst_n (rst_n),
		.tms   (tms),
		.state (state)
	);

	// Instruction register; a new instruction takes effect in Update-IR
	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			ir_sr <= INS_BYPASS;
			ir    <= INS_BYPASS;
		end else begin
			case (state)
				TAP_RESET: ir <= INS_BYPASS;
				TAP_CAPIR: ir_sr <= IR_CAPTURE;
				TAP_SHFIR: ir_sr <= {tdi, ir_sr[IR_W-1:1]}; // RL23 RL24
				TAP_UPDIR: ir <= ir_sr;
				default: ;
			endcase
		end
	end

	// Command register; the page byte is its low eight bits
	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			cmd_sr <= '0;
		end else if (state == TAP_CAPDR && sel_cmd) begin
			cmd_sr <= stat_tck[STAT_W-1:16]; // RL2 RL27
		end else if (state == TAP_CAPDR && ir == INS_PAGE_READ) begin
			cmd_sr[BYTE_W-1:0] <= pr_high ? stat_tck[15:8] : stat_tck[7:0]; // RL10 RL11
		end else if (state == TAP_SHFDR && sel_cmd) begin
			cmd_sr <= {tdi, cmd_sr[CMD_W-1:1]}; // RL3 RL23
		end else if (state == TAP_SHFDR && sel_byte) begin
			cmd_sr[BYTE_W-1:0] <= {tdi, cmd_sr[BYTE_W-1:1]}; // RL6 RL23
		end
	end

	// Apply on update, execute once in a Run-Test/Idle that directly follows it, when in programming mode
	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			cmd_applied  <= '0;
			exec_pending <= 1'b0;
			exec_tgl     <= 1'b0;
		end else if (state == TAP_UPDDR && sel_cmd) begin
			cmd_applied  <= cmd_sr; // RL4
			exec_pending <= 1'b1;
		end else if (state == TAP_IDLE && exec_pending) begin
			exec_pending <= 1'b0;
			exec_tgl     <= exec_tgl ^ prog_mode; // RL5
		end else if (state != TAP_IDLE && state != TAP_UPDDR) begin
			exec_pending <= 1'b0;
		end
	end

	// Page load: byte copied to a holding register, low/high alternation from entry
	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			pl_high   <= 1'b0;
			pl_first  <= 1'b1;
			pl_preinc <= 1'b0;
			pl_byte   <= '0;
			pl_tgl    <= 1'b0;
		end else if (state == TAP_UPDIR) begin
			pl_high  <= 1'b0; // RL8
			pl_first <= 1'b1;
		end else if (state == TAP_UPDDR && ir == INS_PAGE_LOAD) begin
			pl_byte   <= cmd_sr[BYTE_W-1:0]; // RL7
			pl_preinc <= !pl_high && !pl_first; // RL9
			pl_high   <= !pl_high; // RL8
			pl_first  <= 1'b0;
			pl_tgl    <= pl_tgl ^ prog_mode;
		end
	end

	// Page read: alternation, and in programming mode a post-increment after each high byte
	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			pr_high <= 1'b0;
			pr_tgl  <= 1'b0;
		end else if (state == TAP_UPDIR) begin
			pr_high <= 1'b0; // RL11
		end else if (state == TAP_CAPDR && ir == INS_PAGE_READ) begin
			pr_high <= !pr_high; // RL11
			if (pr_high) begin
				pr_tgl <= pr_tgl ^ prog_mode; // RL12
			end
		end
	end

	// Programming enable; power-on reset clears the register and the mode
	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			pe_sr     <= PE_RESET; // RL17
			prog_mode <= 1'b0;
		end else if (state == TAP_SHFDR && sel_pe) begin
			pe_sr <= {tdi, pe_sr[PE_W-1:1]}; // RL23
		end else if (state == TAP_UPDDR && sel_pe) begin
			prog_mode <= (pe_sr == PE_SIGNATURE); // RL16 RL25
		end
	end

	// Reset bit acts on its own value, no update stage; the TAP itself is left alone
	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			rst_bit <= 1'b0;
			bypass  <= 1'b0;
		end else if (state == TAP_SHFDR && sel_rst) begin
			rst_bit <= tdi; // RL13 RL24
		end else if (state == TAP_SHFDR) begin
			bypass <= tdi;
		end else if (state == TAP_CAPDR) begin
			bypass <= 1'b0;
		end
	end

	// Status words arrive by a toggle handshake; the hold register is stable while in flight
	jnp_sync u_sync_req (
		.clk   (tck),
		.rst_n (rst_n),
		.din   (stat_req),
		.q     (stat_req_t)
	);

	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			stat_tck <= '0;
			stat_ack <= 1'b0;
		end else if (stat_req_t != stat_ack) begin
			stat_tck <= stat_hold;
			stat_ack <= stat_req_t;
		end
	end

	always_comb begin
		case (1'b1)
			sel_cmd:  tdo_bit = cmd_sr[0];
			sel_byte: tdo_bit = cmd_sr[0];
			sel_pe:   tdo_bit = pe_sr[0];
			sel_rst:  tdo_bit = rst_bit;
			default:  tdo_bit = bypass;
		endcase
	end

	// TDO changes on the falling edge so the programmer samples a settled bit
	always_ff @(negedge tck or negedge rst_n) begin
		if (!rst_n) begin
			tdo      <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else begin
			tdo      <= (state == TAP_SHFIR) ? ir_sr[0] : tdo_bit;
			tdo_oe_n <= !(state == TAP_SHFIR || state == TAP_SHFDR);
		end
	end

	// ---------------- clk domain logic ----------------
	jnp_sync u_sync_ack (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (stat_ack),
		.q     (stat_ack_c)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_hold <= '0;
			stat_req  <= 1'b0;
		end else if (stat_req == stat_ack_c && stat_hold != {nvm_result, nvm_read_word}) begin
			stat_hold <= {nvm_result, nvm_read_word};
			stat_req  <= !stat_req;
		end
	end

	jnp_sync u_sync_exec (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (exec_tgl),
		.q     (exec_c)
	);

	jnp_sync u_sync_pl (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (pl_tgl),
		.q     (pl_c)
	);

	jnp_sync u_sync_pr (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (pr_tgl),
		.q     (pr_c)
	);

	jnp_sync u_sync_rst (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (rst_bit),
		.q     (rst_bit_c)
	);

	jnp_sync u_sync_pm (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (prog_mode),
		.q     (prog_mode_c)
	);

	// Command words are stable in TCK registers by the time their event toggle lands
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nvm_cmd   <= '0;
			nvm_exec  <= 1'b0;
			exec_seen <= 1'b0;
		end else begin
			exec_seen <= exec_c;
			nvm_exec  <= exec_c != exec_seen; // RL5
			if (exec_c != exec_seen) begin
				nvm_cmd <= cmd_applied; // RL4
			end
		end
	end

	// Pre-increment goes one cycle ahead of the byte write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pl_seen      <= 1'b0;
			pr_seen      <= 1'b0;
			load_pending <= 1'b0;
			load_strobe  <= 1'b0;
			load_byte    <= '0;
			load_high    <= 1'b0;
			pc_inc       <= 1'b0;
		end else begin
			pl_seen      <= pl_c;
			pr_seen      <= pr_c;
			load_pending <= pl_c != pl_seen;
			load_strobe  <= load_pending; // RL7
			pc_inc       <= ((pl_c != pl_seen) && pl_preinc) || (pr_c != pr_seen); // RL9 RL12
			if (load_pending) begin
				load_byte <= pl_byte;
				load_high <= !pl_high; // RL8
			end
		end
	end

	// Core reset: held while the bit is one, then for the selected time-out
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			core_reset   <= 1'b1;
			tmo_cnt      <= '0;
			tmo_arm      <= 1'b1;
			prog_enabled <= 1'b0;
		end else begin
			prog_enabled <= prog_mode_c; // RL16
			tmo_arm      <= 1'b0;
			if (rst_bit_c || tmo_arm) begin
				core_reset <= 1'b1; // RL13
				tmo_cnt    <= clk_opt_long ? TIMEOUT_W'(LONG_TIMEOUT_CYCLES) : TIMEOUT_W'(SHORT_TIMEOUT_CYC);
			end else if (tmo_cnt != '0) begin
				tmo_cnt <= tmo_cnt - TIMEOUT_W'(1); // RL14
			end else begin
				core_reset <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// File: dv/jnp_prog_port_props.sv
`timescale 1ns/10ps
`default_nettype none
module jnp_prog_port_props
	import jnp_pkg::*;
#(
	parameter int LONG_TIMEOUT_CYCLES = LONG_TIMEOUT_CYC
) (
	input wire logic             clk,
	input wire logic             rst_n,
	input wire logic             clk_opt_long,
	input wire logic [CMD_W-1:0] nvm_cmd,
	input wire logic             nvm_exec,
	input wire logic             load_high,
	input wire logic             load_strobe,
	input wire logic             pc_inc,
	input wire logic             core_reset,
	input wire logic             prog_enabled
);
	int hold_cnt;
	// Length of the current core reset, to judge the time-out
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt <= 0;
		end else if (!core_reset) begin
			hold_cnt <= 0;
		end else begin
			hold_cnt <= hold_cnt + 1;
		end
	end
	sequence s_released;
		$rose(rst_n);
	endsequence
	sequence s_held;
		(core_reset && !prog_enabled) [*8];
	endsequence
	a_por_hold: assert property (@(posedge clk) disable iff (!rst_n) s_released |-> s_held)
		else $error("core not held after power-on");
	a_timeout_len: assert property (@(posedge clk) disable iff (!rst_n) $fell(core_reset) |->
		hold_cnt >= (clk_opt_long ? LONG_TIMEOUT_CYCLES : SHORT_TIMEOUT_CYC) - 1)
		else $error("reset released before time-out");
	a_exec_single: assert property (@(posedge clk) disable iff (!rst_n) nvm_exec |=> !nvm_exec)
		else $error("execute pulse too long");
	a_exec_enabled: assert property (@(posedge clk) disable iff (!rst_n) nvm_exec |-> prog_enabled)
		else $error("execute without programming mode");
	a_cmd_applied: assert property (@(posedge clk) disable iff (!rst_n) $changed(nvm_cmd) |-> nvm_exec)
		else $error("command changed without execute");
	a_strobe_single: assert property (@(posedge clk) disable iff (!rst_n) load_strobe |=> !load_strobe)
		else $error("load strobe too long");
	a_strobe_enabled: assert property (@(posedge clk) disable iff (!rst_n) load_strobe |-> prog_enabled)
		else $error("page load without programming mode");
	a_high_no_inc: assert property (@(posedge clk) disable iff (!rst_n)
		load_strobe && load_high |-> !$past(pc_inc))
		else $error("counter stepped before high byte");
	a_pc_single: assert property (@(posedge clk) disable iff (!rst_n) pc_inc |=> !pc_inc)
		else $error("counter step too long");
endmodule
bind jnp_prog_port jnp_prog_port_props #(.LONG_TIMEOUT_CYCLES(LONG_TIMEOUT_CYCLES)) u_props (
	.clk(clk), .rst_n(rst_n), .clk_opt_long(clk_opt_long), .nvm_cmd(nvm_cmd), .nvm_exec(nvm_exec),
	.load_high(load_high), .load_strobe(load_strobe), .pc_inc(pc_inc), .core_reset(core_reset),
	.prog_enabled(prog_enabled));
`default_nettype wire

// File: dv/jnp_programmer.sv
`timescale 1ns/10ps
`default_nettype none
module jnp_programmer (
	output var  logic tck,
	output var  logic tms,
	output var  logic tdi,
	input  wire logic tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// One link clock period; the clock stands still between calls
	task automatic tk(input logic m, input logic d, output logic o);
		#2;
		tms = m;
		tdi = d;
		#78;
		o = tdo;
		tck = 1'b1;
		#80;
		tck = 1'b0;
	endtask
	task automatic walk(input logic [15:0] seq, input int n);
		logic o;
		for (int i = 0; i < n; i++) begin
			tk(seq[i], 1'b0, o);
		end
	endtask
	task automatic shift(input logic [15:0] d, input int n, output logic [15:0] q);
		logic o;
		q = '0;
		for (int i = 0; i < n; i++) begin
			tk(i == n - 1, d[i], o);
			q[i] = o;
		end
	endtask
	task automatic ir(input logic [3:0] code, output logic [3:0] cap);
		logic [15:0] q;
		walk(16'h0003, 4);
		shift({12'h000, code}, 4, q);
		walk(16'h0001, 2);
		cap = q[3:0];
		#2 tdi = ~tdi;
	endtask
	// Six idle periods let the status crossing settle before capture; the last idle period clocks the execute
	task automatic dr(input logic [15:0] d, input int n, output logic [15:0] q);
		walk(16'h0040, 9);
		shift(d, n, q);
		walk(16'h0001, 3);
		#2 tdi = ~tdi;
	endtask
endmodule
`default_nettype wire

// File: dv/jnp_prog_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
module jnp_prog_port_bench;
	import jnp_pkg::*;
	localparam int LONG_T = 20;
	logic             clk, rst_n, tck, tms, tdi, tdo, tdo_oe_n, clk_opt_long;
	logic [CMD_W-1:0] nvm_result, nvm_cmd;
	logic [15:0]      nvm_read_word, q;
	logic             nvm_exec, load_high, load_strobe, pc_inc, core_reset, prog_enabled;
	logic [7:0]       load_byte;
	logic [3:0]       cap;
	int               err_total = 0, n_tests = 0, n_exec = 0, n_strobe = 0, n_pc = 0, n_oe = 0;
	jnp_prog_port #(.LONG_TIMEOUT_CYCLES(LONG_T)) DUT (
		.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
		.clk_opt_long(clk_opt_long), .nvm_result(nvm_result), .nvm_read_word(nvm_read_word),
		.nvm_cmd(nvm_cmd), .nvm_exec(nvm_exec), .load_byte(load_byte), .load_high(load_high),
		.load_strobe(load_strobe), .pc_inc(pc_inc), .core_reset(core_reset), .prog_enabled(prog_enabled));
	jnp_programmer prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Flash model: the addressed word moves on with each counter step
	always @(posedge clk) begin
		n_exec += (nvm_exec === 1'b1);
		n_strobe += (load_strobe === 1'b1);
		n_pc += (pc_inc === 1'b1);
		if (pc_inc === 1'b1) nvm_read_word <= #2 nvm_read_word + 16'h1111;
	end
	// Link edges at which the port drives its serial output
	always @(posedge tck) n_oe += (tdo_oe_n === 1'b0);
	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		if (err_total == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic clk_wait(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic t_power_on;
		chk_bit("core_reset", 1'b1, core_reset);
		chk_bit("prog_enabled", 1'b0, prog_enabled);
		clk_wait(LONG_T + 20);
		chk_bit("core_reset", 1'b0, core_reset);
		prog.walk(16'h0000, 1);
	endtask
	task automatic t_dev_reset;
		clk_wait(1);
		clk_opt_long = 1'b0;
		prog.ir(INS_DEV_RESET, cap);
		chk_word("ir_capture", {12'h000, IR_CAPTURE}, {12'h000, cap});
		prog.dr(16'h0001, 1, q);
		chk_bit("core_reset", 1'b1, core_reset);
		prog.dr(16'h0000, 1, q);
		clk_wait(SHORT_TIMEOUT_CYC - 40);
		chk_bit("core_reset", 1'b1, core_reset);
		clk_wait(60);
		chk_bit("core_reset", 1'b0, core_reset);
	endtask
	task automatic t_enable;
		int e0;
		e0 = n_exec;
		prog.ir(INS_COMMAND, cap);
		prog.dr(16'h2380, 15, q);
		clk_wait(10);
		chk_word("exec_count", 16'd0, 16'(n_exec - e0));
		prog.ir(INS_PROGRAMMING_ENABLE_INSTRUCTION, cap);
		prog.dr(PE_SIGNATURE ^ 16'h8000, 16, q);
		clk_wait(8);
		chk_bit("prog_enabled", 1'b0, prog_enabled);
		prog.dr(PE_SIGNATURE, 16, q);
		clk_wait(8);
		chk_bit("prog_enabled", 1'b1, prog_enabled);
	endtask
	task automatic t_commands;
		logic [14:0] cmds [10];
		logic [14:0] res;
		int          e0, o0;
		cmds = '{15'h2380, 15'h3180, 15'h3380, 15'h3380, 15'h3380, 15'h2310, 15'h175a, 15'h7700,
			15'h2302, 15'h2311};
		prog.ir(INS_COMMAND, cap);
		for (int i = 0; i < 10; i++) begin
			clk_wait(1);
			res = 15'(16'h1357 * (i + 1));
			nvm_result = res;
			e0 = n_exec;
			o0 = n_oe;
			prog.dr({1'b0, cmds[i]}, 15, q);
			chk_word("result_out", {1'b0, res}, q);
			chk_word("oe_low_count", 16'd15, 16'(n_oe - o0));
			clk_wait(10);
			chk_word("nvm_cmd", {1'b0, cmds[i]}, {1'b0, nvm_cmd});
			chk_word("exec_count", 16'd1, 16'(n_exec - e0));
		end
	endtask
	task automatic t_page_load;
		logic [7:0] b;
		int         p0, s0;
		for (int e = 0; e < 2; e++) begin
			prog.ir(INS_PAGE_LOAD, cap);
			for (int i = 0; i < 3; i++) begin
				b = 8'h3c + 8'(i * 65 + e);
				p0 = n_pc;
				s0 = n_strobe;
				prog.dr({8'h00, b}, 8, q);
				clk_wait(64);
				chk_word("load_byte", {8'h00, b}, {8'h00, load_byte});
				chk_bit("load_high", i[0], load_high);
				chk_word("strobe_count", 16'd1, 16'(n_strobe - s0));
				chk_word("pc_inc_count", (i == 2) ? 16'd1 : 16'd0, 16'(n_pc - p0));
			end
		end
	endtask
	task automatic t_page_read;
		logic [15:0] w;
		int          p0;
		clk_wait(1);
		nvm_read_word = 16'h20a5;
		p0 = n_pc;
		prog.ir(INS_PAGE_READ, cap);
		for (int i = 0; i < 5; i++) begin
			if (i == 4) prog.ir(INS_PAGE_READ, cap);
			w = 16'h20a5 + 16'(16'h1111 * (i / 2));
			prog.dr(16'h00ff, 8, q);
			chk_word("read_byte", {8'h00, i[0] ? w[15:8] : w[7:0]}, q);
		end
		clk_wait(8);
		chk_word("pc_inc_count", 16'd2, 16'(n_pc - p0));
	endtask
	task automatic t_leave;
		prog.ir(INS_PROGRAMMING_ENABLE_INSTRUCTION, cap);
		prog.dr(PE_RESET, 16, q);
		clk_wait(8);
		chk_bit("prog_enabled", 1'b0, prog_enabled);
	endtask
	initial begin
		rst_n = 1'b0;
		clk_opt_long = 1'b1;
		nvm_result = '0;
		nvm_read_word = '0;
		prog.walk(16'h001f, 5);
		repeat (10) @(posedge clk);
		#2 rst_n = 1'b1;
		t_power_on;
		t_dev_reset;
		t_enable;
		t_commands;
		t_page_load;
		t_page_read;
		t_leave;
		tally_and_finish;
	end
	initial begin
		#1ms;
		err_total++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
